// File: hdl/twu_timer_watchdog_unit.sv
// Functional notes
// - with interrupts enabled and count end selected as source, every end of count raises a request
// - one bit picks source (count end or pin), two bits route: top-level, A0 or both
// - writing one to pending bit 0 with a route selected traps as if the event happened
// - watchdog reset sets flag bit 6 of clock flag register
// - bit 6 of wait control register enables watchdog mode
// - load value split in two bytes, writable any time; reads return the live counter
// - high byte holds bits 15:8, low byte bits 7:0
// - prescaler divides by programmed value plus one
// - control bit 7 runs counter, bit 6 picks single mode
// - input enable 0: internal/4; mode 00 enable 1: secondary/1024
// - interrupt select 0 uses timer event, 1 uses external pin
// - output field: 00 none, 01 square wave, 1x pwm
//
// Design decision made here: strobed register access.
module twu_timer_watchdog_unit (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// pins and clocks
	input  wire logic       secondary_clock,
	input  wire logic       ext_int_pin,
	input  wire logic       por_b,
	// outputs
	output logic            timer_out,
	output logic            top_level_nmi,
	output logic            chan_a0_req,
	output logic            wd_chip_reset,
	output logic            irq
);
	import twu_pkg::*;

	logic [7:0]  cnt_high_reg, cnt_low_reg, prescale_reg, timer_ctrl_reg;
	logic [7:0]  wait_ctrl_reg, ext_int_vector_reg, int_stat_reg, int_mask_reg;
	logic        watchdog_reset_flag;
	logic [15:0] count_reg;
	logic [7:0]  pre_cnt_reg;
	logic [9:0]  src_cnt_reg;
	logic [2:0]  sec_sync_reg;
	logic [1:0]  pin_sync_reg;
	logic        pin_prev_reg, out_reg, wd_rst_reg, reloaded_reg;
	logic        src_tick, pre_tick, eoc, pin_edge, run, single;
	logic        wr_high, wr_low, wr_ctl, sw_trap, event_src, trap_a0, trap_top;
	logic        wr_pre, wr_wait, wr_vec, wr_mask, wr_flag, wd_fire;
	logic [15:0] pwm_half;
	logic [7:0]  rd_mux;

	assign run      = timer_ctrl_reg[BIT_RUN];
	assign single   = timer_ctrl_reg[BIT_SINGLE];

	// ==========================================================
	// address decode used for several registers, sticky update for two status bits
	function automatic logic hit(input logic strobe, input logic [7:0] addr,
			input logic [7:0] off);
		return strobe && (addr == off);
	endfunction
	// set wins over a write-one clear that falls in the same cycle
	function automatic logic sticky(input logic set, input logic old, input logic clr);
		return set || (old && !clr);
	endfunction
	assign wr_high  = hit(reg_wr, reg_addr, OFF_CNT_HIGH);
	assign wr_low   = hit(reg_wr, reg_addr, OFF_CNT_LOW);
	assign wr_ctl   = hit(reg_wr, reg_addr, OFF_TIMER_CTL);
	assign wr_pre   = hit(reg_wr, reg_addr, OFF_PRESCALE);
	assign wr_wait  = hit(reg_wr, reg_addr, OFF_WAIT_CTL);
	assign wr_vec   = hit(reg_wr, reg_addr, OFF_EXT_VEC);
	assign wr_mask  = hit(reg_wr, reg_addr, OFF_INT_MASK);
	assign wr_flag  = hit(reg_wr, reg_addr, OFF_CLK_FLAG);
	assign sw_trap  = hit(reg_wr, reg_addr, OFF_INT_STAT);

	// ==========================================================
	// synchronisers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sec_sync_reg <= 3'h0;
			pin_sync_reg <= 2'h0;
			pin_prev_reg <= 1'b0;
		end else begin
			sec_sync_reg <= {sec_sync_reg[1:0], secondary_clock};
			pin_sync_reg <= {pin_sync_reg[0], ext_int_pin};
			pin_prev_reg <= pin_sync_reg[1];
		end
	end
	assign pin_edge = pin_sync_reg[1] && !pin_prev_reg;

	// ==========================================================
	// clock source: internal/4 or secondary/1024
	logic sec_rise, use_sec;
	assign sec_rise = sec_sync_reg[1] && !sec_sync_reg[2];
	assign use_sec  = timer_ctrl_reg[BIT_CLK_IN_EN] && !timer_ctrl_reg[BIT_CLK_MODE_HI]
			&& !timer_ctrl_reg[BIT_CLK_MODE_LO];
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			src_cnt_reg <= 10'h000;
		end else if (!run) begin
			src_cnt_reg <= 10'h000;
		end else if (!use_sec || sec_rise) begin
			src_cnt_reg <= src_tick ? 10'h000 : src_cnt_reg + 10'h001;
		end
	end
	// other input modes are not defined here; they fall back to internal/4
	assign src_tick = run && (use_sec
			? (sec_rise && src_cnt_reg == 10'(DIV_SECONDARY - 1))
			: (src_cnt_reg == 10'(DIV_INTERNAL - 1)));

	// ==========================================================
	// prescaler
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pre_cnt_reg <= 8'h00;
		end else if (!run) begin
			pre_cnt_reg <= 8'h00;
		end else if (src_tick) begin
			pre_cnt_reg <= pre_tick ? 8'h00 : pre_cnt_reg + 8'h01;
		end
	end
	assign pre_tick = src_tick && (pre_cnt_reg >= prescale_reg);

	// ==========================================================
	// down counter
	assign eoc = pre_tick && (count_reg == 16'h0000);
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			count_reg <= {RST_CNT_BYTE, RST_CNT_BYTE};
		end else if (wr_ctl && reg_wdata[BIT_RUN] && !run) begin
			count_reg <= {cnt_high_reg, cnt_low_reg};
		end else if (eoc) begin
			count_reg <= {cnt_high_reg, cnt_low_reg};
		end else if (pre_tick) begin
			count_reg <= count_reg - 16'h0001;
		end
	end

	// software reloads by writing either byte; clears the watchdog threat
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reloaded_reg <= 1'b0;
		end else if (wr_low || wr_high) begin
			reloaded_reg <= 1'b1;
		end else if (eoc) begin
			reloaded_reg <= 1'b0;
		end
	end

	// ==========================================================
	// control register: run bit cleared by single mode end of count when watchdog is off
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			timer_ctrl_reg <= RST_TIMER_CTL;
		end else if (wr_ctl) begin
			timer_ctrl_reg <= reg_wdata;
		end else if (eoc && single && !wait_ctrl_reg[BIT_WD_ENABLE]) begin
			timer_ctrl_reg[BIT_RUN] <= 1'b0;
		end
	end

	// ==========================================================
	// software registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_high_reg <= RST_CNT_BYTE;
		end else if (wr_high) begin
			cnt_high_reg <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_low_reg <= RST_CNT_BYTE;
		end else if (wr_low) begin
			cnt_low_reg <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			prescale_reg <= RST_PRESCALE;
		end else if (wr_pre) begin
			prescale_reg <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wait_ctrl_reg <= RST_ZERO;
		end else if (wr_wait) begin
			wait_ctrl_reg <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ext_int_vector_reg <= RST_ZERO;
		end else if (wr_vec) begin
			ext_int_vector_reg <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			int_mask_reg <= RST_ZERO;
		end else if (wr_mask) begin
			int_mask_reg <= reg_wdata;
		end
	end

	// ==========================================================
	// watchdog reset: one-cycle pulse, flag survives it
	assign wd_fire = eoc && wait_ctrl_reg[BIT_WD_ENABLE] && !reloaded_reg;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wd_rst_reg <= 1'b0;
		end else begin
			wd_rst_reg <= wd_fire;
		end
	end
	assign wd_chip_reset = wd_rst_reg;

	// flag is cleared by power-on or by writing zero to bit 6, not by rst_b, so it still reads after the reset it causes
	always_ff @(posedge mclk or negedge por_b) begin
		if (!por_b) begin
			watchdog_reset_flag <= 1'b0;
		end else if (wd_rst_reg) begin
			watchdog_reset_flag <= 1'b1;
		end else if (wr_flag && !reg_wdata[BIT_WD_RST_FLAG]) begin
			watchdog_reset_flag <= 1'b0;
		end
	end

	// ==========================================================
	// interrupt routing
	assign event_src = timer_ctrl_reg[BIT_INT_SRC_SEL] ? pin_edge : eoc;
	assign trap_top  = sw_trap && reg_wdata[BIT_ST_EOC] && ext_int_vector_reg[BIT_TOP_LEVEL_SEL];
	assign trap_a0   = sw_trap && reg_wdata[BIT_ST_EOC] && ext_int_vector_reg[BIT_CHAN_A0_SEL];
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			top_level_nmi <= 1'b0;
			chan_a0_req   <= 1'b0;
		end else begin
			top_level_nmi <= (event_src && ext_int_vector_reg[BIT_TOP_LEVEL_SEL])
					|| trap_top;
			chan_a0_req   <= (event_src && ext_int_vector_reg[BIT_CHAN_A0_SEL])
					|| trap_a0;
		end
	end

	// sticky status: set beats write-one clear; bit 0 also set by writing one (trap) when a route bit is set
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			int_stat_reg <= RST_ZERO;
		end else begin
			int_stat_reg[BIT_ST_EOC] <= sticky(event_src || trap_top || trap_a0,
					int_stat_reg[BIT_ST_EOC], sw_trap && reg_wdata[BIT_ST_EOC]);
			int_stat_reg[BIT_ST_WDRST] <= sticky(wd_rst_reg,
					int_stat_reg[BIT_ST_WDRST], sw_trap && reg_wdata[BIT_ST_WDRST]);
		end
	end
	assign irq = |(int_stat_reg & int_mask_reg);

	// ==========================================================
	// timer output
	assign pwm_half = {1'b0, cnt_high_reg, cnt_low_reg[7:1]};
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			out_reg <= 1'b0;
		end else begin
			case (timer_ctrl_reg[BIT_OUT_MODE_HI:BIT_OUT_MODE_LO])
				OUT_NONE:   out_reg <= 1'b0;
				OUT_SQUARE: out_reg <= eoc ? !out_reg : out_reg;
				// pwm: high while count sits in the lower half of the load value
				default:    out_reg <= count_reg < pwm_half;
			endcase
		end
	end
	assign timer_out = out_reg;

	// ==========================================================
	// read port: live counter, no latch, so a byte pair read may straddle a tick
	always_comb begin
		case (reg_addr)
			OFF_CNT_HIGH:  rd_mux = count_reg[15:8];
			OFF_CNT_LOW:   rd_mux = count_reg[7:0];
			OFF_PRESCALE:  rd_mux = prescale_reg;
			OFF_TIMER_CTL: rd_mux = timer_ctrl_reg;
			OFF_WAIT_CTL:  rd_mux = wait_ctrl_reg;
			OFF_EXT_VEC:   rd_mux = ext_int_vector_reg;
			OFF_CLK_FLAG:  rd_mux = {1'b0, watchdog_reset_flag, 6'h00};
			OFF_INT_STAT:  rd_mux = int_stat_reg;
			OFF_INT_MASK:  rd_mux = int_mask_reg;
			default:       rd_mux = RST_ZERO;
		endcase
	end
	// data stands only in the cycle after the strobe, zero otherwise
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= RST_ZERO;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : RST_ZERO;
		end
	end
endmodule // twu_timer_watchdog_unit

// File: hdl/twu_pkg.sv
package twu_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] OFF_CNT_HIGH  = 8'hF8;
	localparam logic [7:0] OFF_CNT_LOW   = 8'hF9;
	localparam logic [7:0] OFF_PRESCALE  = 8'hFA;
	localparam logic [7:0] OFF_TIMER_CTL = 8'hFB;
	localparam logic [7:0] OFF_WAIT_CTL  = 8'hFC;
	localparam logic [7:0] OFF_EXT_VEC   = 8'hFD;
	localparam logic [7:0] OFF_CLK_FLAG  = 8'hFE;
	localparam logic [7:0] OFF_INT_STAT  = 8'hF0;
	localparam logic [7:0] OFF_INT_MASK  = 8'hF1;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_CNT_BYTE  = 8'hFF;
	localparam logic [7:0] RST_PRESCALE  = 8'hFF;
	localparam logic [7:0] RST_TIMER_CTL = 8'h00;
	localparam logic [7:0] RST_ZERO      = 8'h00;
	// ==========================================================
	// field positions
	localparam int BIT_RUN         = 7;
	localparam int BIT_SINGLE      = 6;
	localparam int BIT_CLK_MODE_HI   = 5;
	localparam int BIT_CLK_MODE_LO   = 4;
	localparam int BIT_CLK_IN_EN     = 3;
	localparam int BIT_INT_SRC_SEL   = 2;
	localparam int BIT_OUT_MODE_HI   = 1;
	localparam int BIT_OUT_MODE_LO   = 0;
	localparam int BIT_WD_ENABLE     = 6;
	localparam int BIT_TOP_LEVEL_SEL = 2;
	localparam int BIT_CHAN_A0_SEL   = 1;
	localparam int BIT_WD_RST_FLAG = 6;
	localparam int BIT_ST_EOC      = 0;
	localparam int BIT_ST_WDRST    = 1;
	// ==========================================================
	// clock source dividers
	localparam int DIV_INTERNAL  = 4;
	localparam int DIV_SECONDARY = 1024;
	// ==========================================================
	// output modes
	localparam logic [1:0] OUT_NONE   = 2'h0;
	localparam logic [1:0] OUT_SQUARE = 2'h1;
endpackage

// File: tb/twu_properties.sv
module twu_properties (
	// watched ports
	input wire logic       mclk,
	input wire logic       rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       irq,
	input wire logic       top_level_nmi,
	input wire logic       chan_a0_req,
	input wire logic       wd_chip_reset
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// register port and event outputs
	property rb(a, m);
		reg_wr && reg_addr == a ##2 reg_rd && reg_addr == a
		|=> ((reg_rdata ^ $past(reg_wdata, 3)) & m) == 8'h00;
	endproperty
	prescale_rb_a: assert property (rb(8'hFA, 8'hFF)) else $error("prescaler readback");
	control_rb_a: assert property (rb(8'hFB, 8'hFF)) else $error("control readback");
	wd_enable_rb_a: assert property (rb(8'hFC, 8'h40)) else $error("wd enable readback");
	route_rb_a: assert property (rb(8'hFD, 8'h06)) else $error("route bits readback");
	mask_rb_a: assert property (rb(8'hF1, 8'h03)) else $error("mask readback");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	unmapped_rd_a: assert property ($past(reg_rd)
		&& !($past(reg_addr) inside {8'hF0, 8'hF1, [8'hF8:8'hFE]}) |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	mask_irq_a: assert property (reg_wr && reg_addr == 8'hF1 && reg_wdata == 8'h00 |=> !irq)
		else $error("irq with all masked");
	wd_pulse_a: assert property (wd_chip_reset |=> !wd_chip_reset)
		else $error("chip reset pulse too long");
	wd_flag_a: assert property ($past(wd_chip_reset, 2) && $past(reg_rd)
		&& $past(reg_addr) == 8'hFE |-> reg_rdata[6]) else $error("reset flag not set");
	cover property (top_level_nmi && chan_a0_req);
	cover property (wd_chip_reset);
	cover property (irq ##1 !irq);
endmodule // twu_properties

bind twu_timer_watchdog_unit twu_properties chk (.mclk, .rst_b, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .irq, .top_level_nmi, .chan_a0_req, .wd_chip_reset);

// File: tb/twu_core_model.sv
module twu_core_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// requests from the unit
	input  wire logic       top_level_nmi,
	input  wire logic       chan_a0_req,
	input  wire logic       wd_chip_reset,
	// tallies seen by the core
	output logic      [7:0] nmi_cnt,
	output logic      [7:0] a0_cnt,
	output logic      [7:0] wdr_cnt
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// request intake: one entry per single-cycle pulse
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			nmi_cnt <= 8'h00;
			a0_cnt <= 8'h00;
			wdr_cnt <= 8'h00;
		end else begin
			nmi_cnt <= nmi_cnt + {7'h00, top_level_nmi};
			a0_cnt <= a0_cnt + {7'h00, chan_a0_req};
			wdr_cnt <= wdr_cnt + {7'h00, wd_chip_reset};
		end
	end
endmodule // twu_core_model

// File: tb/twu_timer_watchdog_unit_tb.sv
module twu_timer_watchdog_unit_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       mclk = 1'b0, rst_b = 1'b0, por_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [7:0] reg_rdata, nmi_cnt, a0_cnt, wdr_cnt, d, c, c2;
	logic       timer_out, top_level_nmi, chan_a0_req, wd_chip_reset, irq;
	logic       sec_clk = 1'b0, ext_pin = 1'b0, o1;
	int         fail_count = 0, num_checks = 0, n;
	always #2.5 mclk = ~mclk;
	always #10 sec_clk = ~sec_clk;
	twu_timer_watchdog_unit dut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .secondary_clock(sec_clk), .ext_int_pin(ext_pin), .por_b, .timer_out,
		.top_level_nmi, .chan_a0_req, .wd_chip_reset, .irq);
	twu_core_model core (.mclk, .rst_b, .top_level_nmi, .chan_a0_req, .wd_chip_reset,
		.nmi_cnt, .a0_cnt, .wdr_cnt);
	// ==========================================================
	// bus cycles and checks
	task wr(input logic [7:0] a, v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task chk(input string n, input logic [7:0] e, g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task rc(input string n, input logic [7:0] a, e, m);
		rd(a);
		chk(n, e, d & m);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// bounded wait for irq (0) or chip reset (1)
	task wt(input logic k, input int lim, output int cyc);
		cyc = 0;
		do begin
			@(posedge mclk);
			#1;
			cyc++;
		end while ((k ? wd_chip_reset : irq) !== 1'b1 && cyc < lim);
		if ((k ? wd_chip_reset : irq) !== 1'b1) begin
			fail_count++;
			end_sim();
		end
	endtask
	task trap(input logic [7:0] r, dn, da);
		wr(8'hFD, r);
		c = nmi_cnt;
		c2 = a0_cnt;
		wr(8'hF0, 8'h01);
		repeat (3) @(posedge mclk);
		#1;
		chk("trap_nmi", c + dn, nmi_cnt);
		chk("trap_a0", c2 + da, a0_cnt);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs;
		logic [7:0] a[5] = '{8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hF1};
		logic [7:0] v[5] = '{8'h00, 8'h3D, 8'h40, 8'h06, 8'h03};
		logic [7:0] m[5] = '{8'hFF, 8'hFF, 8'h40, 8'h06, 8'h03};
		rc("cnt_hi", 8'hF8, 8'hFF, 8'hFF);
		rc("cnt_lo", 8'hF9, 8'hFF, 8'hFF);
		rc("unmapped", 8'h10, 8'h00, 8'hFF);
		for (int i = 0; i < 5; i++) begin
			rc("reset_val", a[i], (i == 0) ? 8'hFF : 8'h00, 8'hFF);
			wr(a[i], v[i]);
			rc("readback", a[i], v[i], m[i]);
		end
		wr(8'hFC, 8'h00);
		$display("t_regs done");
	endtask
	task t_out;
		wr(8'hFC, 8'h00);
		wr(8'hFD, 8'h00);
		wr(8'hF0, 8'h03);
		wr(8'hF1, 8'h01);
		chk("out_none", 8'h00, {7'h00, timer_out});
		wr(8'hFB, 8'h81);
		wt(1'b0, 400, n);
		o1 = timer_out;
		chk("square_hi", 8'h01, {7'h00, o1});
		wr(8'hF0, 8'h01);
		wt(1'b0, 400, n);
		chk("square_tgl", {7'h00, ~o1}, {7'h00, timer_out});
		wr(8'hFB, 8'h00);
		wr(8'hF0, 8'h01);
		$display("t_out done");
	endtask
	task t_pin;
		wr(8'hFB, 8'h04);
		wr(8'hFD, 8'h04);
		c = nmi_cnt;
		c2 = a0_cnt;
		ext_pin <= 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		chk("pin_nmi", c + 8'h01, nmi_cnt);
		chk("pin_a0", c2, a0_cnt);
		ext_pin <= 1'b0;
		repeat (3) @(posedge mclk);
		wr(8'hFB, 8'h00);
		wr(8'hFD, 8'h00);
		wr(8'hF0, 8'h01);
		$display("t_pin done");
	endtask
	task t_sec;
		wr(8'hF9, 8'h00);
		wr(8'hFB, 8'hC8);
		wt(1'b0, 5000, n);
		chk("sec_div", 8'h01, {7'h00, n > 4000 && n < 4200});
		wr(8'hFB, 8'h00);
		$display("t_sec done");
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		por_b <= 1'b1;
		t_regs();
		wr(8'hF8, 8'h00);
		wr(8'hF9, 8'h03);
		wr(8'hF1, 8'h01);
		chk("irq_idle", 8'h00, {7'h00, irq});
		wr(8'hFB, 8'hC0);
		rc("live_hi", 8'hF8, 8'h00, 8'hFF);
		wt(1'b0, 400, n);
		chk("eoc_time", 8'h01, {7'h00, n >= 12 && n <= 16});
		rc("single_stop", 8'hFB, 8'h40, 8'hFF);
		wr(8'hF1, 8'h00);
		chk("irq_masked", 8'h00, {7'h00, irq});
		$display("t_eoc done");
		trap(8'h06, 8'h01, 8'h01);
		trap(8'h02, 8'h00, 8'h01);
		trap(8'h04, 8'h01, 8'h00);
		rc("trap_pend", 8'hF0, 8'h01, 8'h01);
		$display("t_trap done");
		wr(8'hF1, 8'h02);
		wr(8'hFC, 8'h40);
		wr(8'hFB, 8'h80);
		wt(1'b1, 400, n);
		rc("wd_flag", 8'hFE, 8'h40, 8'h40);
		chk("wd_cnt", 8'h01, wdr_cnt);
		chk("wd_irq", 8'h01, {7'h00, irq});
		wr(8'hF0, 8'h02);
		chk("wd_clr", 8'h00, {7'h00, irq});
		wr(8'hFB, 8'h00);
		$display("t_wd done");
		t_out();
		t_pin();
		t_sec();
		end_sim();
	end
endmodule // twu_timer_watchdog_unit_tb
